//--- hw/sct_timer.sv
module sct_timer
  import sct_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire sct_req_s bus_req,
  output logic [15:0] bus_rdata,
  input wire logic osc_mode_bit,
  input wire logic timer_input_a,
  input wire logic timer_input_b,
  input wire logic watch_tick,
  input wire logic sub_clock_tick,
  output logic timer_out_pin,
  output logic prog_clock_out,
  output logic first_match_irq,
  output logic second_match_irq,
  output logic pin_irq_flag_a
);

  logic [7:0] count_clock_select_q;
  logic [7:0] timer_mode_control_q;
  logic [7:0] capcomp_control_q;
  logic [7:0] timer_output_control_q;
  logic [7:0] edge_select_control_q;
  logic [15:0] count_value_q;
  logic [15:0] capture_compare_first_q;
  logic [15:0] capture_compare_second_q;
  logic [DIV_W-1:0] div_q;
  logic [2:0] sync_a_q;
  logic [2:0] sync_b_q;
  logic [2:0] watch_q;
  logic [2:0] sub_q;
  logic out_q;
  logic pcl_q;
  logic oneshot_armed_q;
  logic [15:0] rdata_d;

  sct_op_e op_mode;
  logic cap_first_mode, cap_second_mode, first_src_b;
  logic a_rise, a_fall, b_rise, b_fall, a_valid, b_valid;
  logic [1:0] edge_sel;
  logic fxx_tick;
  logic [DIV_W-1:0] fxx_div;
  logic count_tick;
  logic first_eq, second_eq;
  logic cmp1_hit, cmp2_hit;
  logic cap1_trig, cap2_trig, clear_cnt;
  logic wr_clksel, wr_mode, wr_first, wr_second;
  logic rd_second, rd_count;

  // field decode
  assign op_mode = sct_op_e'(timer_mode_control_q[MODE_OP_LSB +: 3]);
  assign cap_first_mode = capcomp_control_q[CAPCOMP_FIRST_BIT];
  assign cap_second_mode = capcomp_control_q[CAPCOMP_SECOND_BIT];
  assign first_src_b = capcomp_control_q[CAPCOMP_FIRST_SRC_BIT];
  assign edge_sel = edge_select_control_q[EDGE_SEL_LSB +: 2];

  // bus strobes
  assign wr_clksel = bus_req.wr && bus_req.addr == ADDR_COUNT_CLOCK_SELECT;
  assign wr_mode = bus_req.wr && bus_req.addr == ADDR_TIMER_MODE_CONTROL;
  assign wr_first = bus_req.wr && bus_req.addr == ADDR_CAPTURE_COMPARE_FIRST;
  assign wr_second = bus_req.wr && bus_req.addr == ADDR_CAPTURE_COMPARE_SECOND;
  assign rd_second = bus_req.rd &&
    bus_req.addr == ADDR_CAPTURE_COMPARE_SECOND;
  assign rd_count = bus_req.rd && bus_req.addr == ADDR_COUNT_VALUE;

  // two-flop synchronisers plus an edge stage; only the second flop
  // feeds logic, the third keeps the previous level for edge detection
  // input pins reset to their high idle level so no false edge follows
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_q <= 3'h7;
      sync_b_q <= 3'h7;
      watch_q <= 3'h0;
      sub_q <= 3'h0;
    end else begin
      sync_a_q <= {sync_a_q[1:0], timer_input_a};
      sync_b_q <= {sync_b_q[1:0], timer_input_b};
      watch_q <= {watch_q[1:0], watch_tick};
      sub_q <= {sub_q[1:0], sub_clock_tick};
    end
  end

  // edges seen on the synchronised pins
  assign a_rise = sync_a_q[1] && !sync_a_q[2];
  assign a_fall = !sync_a_q[1] && sync_a_q[2];
  assign b_rise = sync_b_q[1] && !sync_b_q[2];
  assign b_fall = !sync_b_q[1] && sync_b_q[2];

  // pin a valid edge per edge-select code; pin b valid on its rising edge only
  always_comb begin
    case (edge_sel)
      EDGE_FALL: a_valid = a_fall;
      EDGE_RISE: a_valid = a_rise;
      EDGE_BOTH: a_valid = a_rise || a_fall;
      default: a_valid = 1'b0;
    endcase
  end
  assign b_valid = b_rise;

  // first capture uses pin b rising edge when its source bit is set, else the opposite edge of pin a; both-edges disables
  always_comb begin
    if (first_src_b) begin
      cap1_trig = b_valid;
    end else begin
      case (edge_sel)
        EDGE_FALL: cap1_trig = a_rise;
        EDGE_RISE: cap1_trig = a_fall;
        default: cap1_trig = 1'b0;
      endcase
    end
  end
  assign cap2_trig = a_valid;

  // free-running prescaler on the main clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // prescaler source: halved main clock unless mode bit set
  // the divider runs freely, so tick phase is arbitrary after a restart
  assign fxx_tick = osc_mode_bit ? 1'b1 : div_q[0];
  assign fxx_div = osc_mode_bit ? div_q : {1'b0, div_q[DIV_W-1:1]};

  // count clock selection; prohibited codes never count
  // code 1 is the undivided main clock, legal only with mode bit 0
  // codes 2 to 4 step down from the prescaler source by powers of two
  always_comb begin
    case (count_clock_select_q[CLKSEL_COUNT_LSB +: 3])
      CNT_SRC_PIN: count_tick = a_valid;
      3'h1: count_tick = !osc_mode_bit;
      3'h2: count_tick = fxx_tick;
      3'h3: count_tick = fxx_tick && fxx_div[0:0] == 1'h1;
      3'h4: count_tick = fxx_tick && fxx_div[1:0] == 2'h3;
      CNT_SRC_WATCH: count_tick = watch_q[1] && !watch_q[2];
      default: count_tick = 1'b0;
    endcase
  end

  // compare hits; equality is continuous
  assign first_eq = count_value_q == capture_compare_first_q;
  assign second_eq = count_value_q == capture_compare_second_q;
  assign cmp1_hit = !cap_first_mode && first_eq && count_tick;
  assign cmp2_hit = !cap_second_mode && second_eq && count_tick;

  // clear conditions for the clear-and-start modes
  always_comb begin
    case (op_mode)
      SCT_OP_EDGE_A, SCT_OP_EDGE_B: clear_cnt = a_valid;
      SCT_OP_MATCH_A, SCT_OP_MATCH_B: clear_cnt = cmp1_hit;
      default: clear_cnt = 1'b0;
    endcase
  end

  // counter: held at zero in stop, wraps through overflow otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value_q <= COUNT_RESET;
    end else if (op_mode == SCT_OP_STOP) begin
      count_value_q <= COUNT_RESET;
    end else if (clear_cnt) begin
      count_value_q <= COUNT_RESET;
    end else if (count_tick) begin
      count_value_q <= count_value_q + 16'h0001;
    end
  end

  // first register: no reset, written or captured
  always_ff @(posedge ref_clk) begin
    if (wr_first) begin
      capture_compare_first_q <= bus_req.wdata;
    end else if (cap_first_mode && cap1_trig) begin
      capture_compare_first_q <= count_value_q;
    end
  end

  // second register: count read copies count, capture skipped on read
  always_ff @(posedge ref_clk) begin
    if (rd_count) begin
      capture_compare_second_q <= count_value_q;
    end else if (wr_second) begin
      capture_compare_second_q <= bus_req.wdata;
    end else if (cap_second_mode && cap2_trig && !rd_second) begin
      capture_compare_second_q <= count_value_q;
    end
  end

  // control registers, low byte written whole when be[0] is set, no bit-level masks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_clock_select_q <= CLKSEL_RESET;
      capcomp_control_q <= CTRL_RESET;
      timer_output_control_q <= CTRL_RESET;
      edge_select_control_q <= CTRL_RESET;
    end else if (bus_req.wr && bus_req.be[0]) begin
      if (wr_clksel) count_clock_select_q <= bus_req.wdata[7:0];
      if (bus_req.addr == ADDR_CAPCOMP_CONTROL)
        capcomp_control_q <= bus_req.wdata[7:0];
      if (bus_req.addr == ADDR_TIMER_OUTPUT_CONTROL)
        timer_output_control_q <= bus_req.wdata[7:0];
      if (bus_req.addr == ADDR_EDGE_SELECT_CONTROL)
        edge_select_control_q <= bus_req.wdata[7:0];
    end
  end

  // mode register; overflow flag set wins over software clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_mode_control_q <= MODE_RESET;
    end else begin
      if (wr_mode && bus_req.be[0]) begin
        timer_mode_control_q[3:1] <= bus_req.wdata[3:1];
      end
      if (count_tick && !clear_cnt && op_mode != SCT_OP_STOP &&
          count_value_q == 16'hffff) begin
        timer_mode_control_q[MODE_OVF_BIT] <= 1'b1;
      end else if (wr_mode && bus_req.be[0]) begin
        timer_mode_control_q[MODE_OVF_BIT] <= bus_req.wdata[0];
      end
    end
  end

  // interrupt request pulses; no match pulses while stopped, pin a flag pulses in every mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_match_irq <= 1'b0;
      second_match_irq <= 1'b0;
      pin_irq_flag_a <= 1'b0;
    end else begin
      first_match_irq <= cmp1_hit && op_mode != SCT_OP_STOP;
      second_match_irq <= cmp2_hit && op_mode != SCT_OP_STOP;
      pin_irq_flag_a <= a_valid;
    end
  end

  // output control: pwm, toggle on match, or one-shot pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
      oneshot_armed_q <= 1'b0;
    end else if (!timer_output_control_q[OUTCTL_ENABLE_BIT]) begin
      out_q <= 1'b0;
      oneshot_armed_q <= 1'b0;
    end else if (op_mode == SCT_OP_PWM) begin
      out_q <= count_value_q[15:2] < capture_compare_first_q[15:2];
    end else if (timer_output_control_q[OUTCTL_ONESHOT_BIT]) begin
      if (timer_output_control_q[OUTCTL_TRIG_BIT] && !oneshot_armed_q &&
          !out_q) begin
        oneshot_armed_q <= 1'b1;
      end else if (oneshot_armed_q && cmp2_hit) begin
        out_q <= 1'b1;
      end else if (oneshot_armed_q && out_q && cmp1_hit) begin
        out_q <= 1'b0;
        oneshot_armed_q <= 1'b0;
      end
    end else if (op_mode != SCT_OP_STOP && (cmp1_hit || cmp2_hit)) begin
      out_q <= !out_q;
    end
  end
  assign timer_out_pin = out_q;

  // programmable clock output, divided from main or sub clock
  // the sub clock source toggles once per synchronised change
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcl_q <= 1'b0;
    end else if (!count_clock_select_q[CLKSEL_OUT_EN_BIT]) begin
      pcl_q <= 1'b0;
    end else begin
      case (count_clock_select_q[3:0])
        4'h0: pcl_q <= sub_q[1] ^ sub_q[2] ? !pcl_q : pcl_q;
        4'h5: pcl_q <= fxx_tick ? !pcl_q : pcl_q;
        4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc: begin
          if (fxx_tick && (fxx_div & ((DIV_W'(1) <<
              (count_clock_select_q[3:0] - 4'h5)) - DIV_W'(1))) ==
              ((DIV_W'(1) << (count_clock_select_q[3:0] - 4'h5))
              - DIV_W'(1)))
            pcl_q <= !pcl_q;
        end
        default: pcl_q <= 1'b0;
      endcase
    end
  end
  assign prog_clock_out = pcl_q;

  // read mux; count read returns the live count register directly
  always_comb begin
    case (bus_req.addr)
      ADDR_COUNT_CLOCK_SELECT: rdata_d = {8'h00, count_clock_select_q};
      ADDR_TIMER_MODE_CONTROL: rdata_d = {12'h000, timer_mode_control_q[3:0]};
      ADDR_CAPCOMP_CONTROL: rdata_d = {8'h00, capcomp_control_q};
      ADDR_TIMER_OUTPUT_CONTROL: rdata_d = {8'h00, timer_output_control_q};
      ADDR_EDGE_SELECT_CONTROL: rdata_d = {8'h00, edge_select_control_q};
      ADDR_CAPTURE_COMPARE_FIRST: rdata_d = capture_compare_first_q;
      ADDR_CAPTURE_COMPARE_SECOND: rdata_d = capture_compare_second_q;
      ADDR_COUNT_VALUE: rdata_d = count_value_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // registered read data, valid the cycle after rd
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 16'h0000;
    end else if (bus_req.rd) begin
      bus_rdata <= rdata_d;
    end
  end

endmodule // sct_timer

//--- shared/sct_pkg.sv
package sct_pkg;
  // register addresses on the peripheral byte bus
  localparam logic [7:0] ADDR_COUNT_CLOCK_SELECT = 8'h40;
  localparam logic [7:0] ADDR_TIMER_MODE_CONTROL = 8'h48;
  localparam logic [7:0] ADDR_CAPCOMP_CONTROL = 8'h4c;
  localparam logic [7:0] ADDR_TIMER_OUTPUT_CONTROL = 8'h4e;
  localparam logic [7:0] ADDR_EDGE_SELECT_CONTROL = 8'h4a;
  localparam logic [7:0] ADDR_CAPTURE_COMPARE_FIRST = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE_COMPARE_SECOND = 8'h12;
  localparam logic [7:0] ADDR_COUNT_VALUE = 8'h14;
  // reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] CLKSEL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // field positions
  localparam int CLKSEL_OUT_EN_BIT = 7;
  localparam int CLKSEL_COUNT_LSB = 4;
  localparam int MODE_OVF_BIT = 0;
  localparam int MODE_OP_LSB = 1;
  localparam int CAPCOMP_FIRST_BIT = 0;
  localparam int CAPCOMP_FIRST_SRC_BIT = 1;
  localparam int CAPCOMP_SECOND_BIT = 2;
  localparam int OUTCTL_ENABLE_BIT = 0;
  localparam int OUTCTL_ONESHOT_BIT = 1;
  localparam int OUTCTL_TRIG_BIT = 2;
  localparam int EDGE_SEL_LSB = 2;
  // operating modes
  typedef enum logic [2:0] {
    SCT_OP_STOP = 3'h0,
    SCT_OP_PWM = 3'h1,
    SCT_OP_FREE_A = 3'h2,
    SCT_OP_FREE_B = 3'h3,
    SCT_OP_EDGE_A = 3'h4,
    SCT_OP_EDGE_B = 3'h5,
    SCT_OP_MATCH_A = 3'h6,
    SCT_OP_MATCH_B = 3'h7
  } sct_op_e;
  // pin edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // count clock codes
  localparam logic [2:0] CNT_SRC_PIN = 3'h0;
  localparam logic [2:0] CNT_SRC_WATCH = 3'h7;
  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
  } sct_req_s;
endpackage

//--- verification/sct_pin_model.sv
module sct_pin_model
  import sct_pkg::*;
#(
  parameter int HOLD = 8
) (
  input wire logic ref_clk,
  output logic timer_input_a,
  output logic timer_input_b,
  output logic watch_tick,
  output logic sub_clock_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle levels: input pins high, tick lines low
  initial begin
    timer_input_a = 1'b1;
    timer_input_b = 1'b1;
    watch_tick = 1'b0;
    sub_clock_tick = 1'b0;
  end
  // drive one line: 0 pin a, 1 pin b, else watch tick (inverted)
  task automatic put(input int sel, input logic v);
    if (sel == 0) timer_input_a = v;
    else if (sel == 1) timer_input_b = v;
    else watch_tick = !v;
  endtask
  // low then high pulses, each level held past the synchroniser
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1 put(sel, 1'b0);
      repeat (HOLD) @(posedge ref_clk);
      #1 put(sel, 1'b1);
      repeat (HOLD - 1) @(posedge ref_clk);
    end
  endtask
  // slow sub clock changes, spaced for synchronising
  task automatic toggle_sub(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1 sub_clock_tick = !sub_clock_tick;
      repeat (HOLD) @(posedge ref_clk);
    end
  endtask
endmodule // sct_pin_model

//--- verification/sct_timer_sva.sv
module sct_timer_sva
  import sct_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire sct_req_s bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic timer_input_a,
  input wire logic prog_clock_out,
  input wire logic first_match_irq,
  input wire logic second_match_irq,
  input wire logic pin_irq_flag_a
);
  timeunit 1ns;
  timeprecision 100ps;
  logic a_q;
  logic [3:0] since_a_q;
  logic pcl_en_q;
  logic stop_q;
  logic mapped;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // cycles since pin a last moved, saturating
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q <= 1'b1;
      since_a_q <= 4'hf;
    end else begin
      a_q <= timer_input_a;
      if (timer_input_a != a_q) since_a_q <= 4'h0;
      else if (since_a_q != 4'hf) since_a_q <= since_a_q + 4'h1;
    end
  end
  // clock output enable and stop state seen on bus writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcl_en_q <= 1'b0;
      stop_q <= 1'b1;
    end else if (bus_req.wr && bus_req.be[0]) begin
      if (bus_req.addr == ADDR_COUNT_CLOCK_SELECT)
        pcl_en_q <= bus_req.wdata[CLKSEL_OUT_EN_BIT];
      if (bus_req.addr == ADDR_TIMER_MODE_CONTROL)
        stop_q <= (bus_req.wdata[3:1] == 3'h0);
    end
  end
  // addresses that decode to a register
  assign mapped = bus_req.addr inside {ADDR_COUNT_CLOCK_SELECT,
    ADDR_TIMER_MODE_CONTROL, ADDR_CAPCOMP_CONTROL, ADDR_TIMER_OUTPUT_CONTROL,
    ADDR_EDGE_SELECT_CONTROL, ADDR_CAPTURE_COMPARE_FIRST,
    ADDR_CAPTURE_COMPARE_SECOND, ADDR_COUNT_VALUE};
  property p_first_pulse;
    first_match_irq |=> !first_match_irq;
  endproperty
  a_first_pulse: assert property (p_first_pulse)
    else $error("first match pulse longer than one cycle");
  property p_second_pulse;
    $rose(second_match_irq) |=> $fell(second_match_irq);
  endproperty
  a_second_pulse: assert property (p_second_pulse)
    else $error("second match pulse longer than one cycle");
  property p_pin_lag;
    pin_irq_flag_a |-> since_a_q inside {[4'h1:4'h8]};
  endproperty
  a_pin_lag: assert property (p_pin_lag)
    else $error("pin flag not tied to a synchronised pin change");
  property p_pin_pulse;
    pin_irq_flag_a |=> !pin_irq_flag_a;
  endproperty
  a_pin_pulse: assert property (p_pin_pulse)
    else $error("pin flag longer than one cycle");
  property p_pcl_off;
    !pcl_en_q [*3] |-> !prog_clock_out;
  endproperty
  a_pcl_off: assert property (p_pcl_off)
    else $error("clock output active while disabled");
  property p_stop_quiet;
    stop_q [*3] |-> !first_match_irq && !second_match_irq;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("match pulse in stop mode");
  property p_rdata_hold;
    !$past(bus_req.rd) |-> $stable(bus_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
  property p_unmapped_zero;
    bus_req.rd && !mapped |=> bus_rdata == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned nonzero");
  property p_clksel_width;
    bus_req.rd && bus_req.addr == ADDR_COUNT_CLOCK_SELECT
      |=> bus_rdata[15:8] == 8'h00;
  endproperty
  a_clksel_width: assert property (p_clksel_width)
    else $error("clock select read wider than a byte");
endmodule // sct_timer_sva

bind sct_timer sct_timer_sva #(.DIV_W(DIV_W)) sct_timer_sva_i (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .bus_req(bus_req),
  .bus_rdata(bus_rdata),
  .timer_input_a(timer_input_a),
  .prog_clock_out(prog_clock_out),
  .first_match_irq(first_match_irq),
  .second_match_irq(second_match_irq),
  .pin_irq_flag_a(pin_irq_flag_a)
);

//--- verification/testbench.sv
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, g, e); \
  end \
end

module testbench
  import sct_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rst_n, osc_mode_bit;
  sct_req_s bus_req;
  logic [15:0] bus_rdata, got, prev;
  logic timer_input_a, timer_input_b, watch_tick, sub_clock_tick;
  logic timer_out_pin, prog_clock_out, first_match_irq, second_match_irq;
  logic pin_irq_flag_a;
  int n_mismatch, samples_checked, n_m1, n_m2, n_pin, n_pcl, n;
  int codes[3] = '{0, 1, 3};

  sct_timer sct_timer_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .osc_mode_bit(osc_mode_bit),
    .timer_input_a(timer_input_a), .timer_input_b(timer_input_b),
    .watch_tick(watch_tick), .sub_clock_tick(sub_clock_tick),
    .timer_out_pin(timer_out_pin), .prog_clock_out(prog_clock_out),
    .first_match_irq(first_match_irq), .second_match_irq(second_match_irq),
    .pin_irq_flag_a(pin_irq_flag_a));
  sct_pin_model sct_pin_model_i (.ref_clk(ref_clk),
    .timer_input_a(timer_input_a), .timer_input_b(timer_input_b),
    .watch_tick(watch_tick), .sub_clock_tick(sub_clock_tick));

  always #2 ref_clk = ~ref_clk;
  // tallies of the one-cycle pulses and clock output changes
  always @(posedge ref_clk) begin
    if (first_match_irq === 1'b1) n_m1++;
    if (second_match_irq === 1'b1) n_m2++;
    if (pin_irq_flag_a === 1'b1) n_pin++;
  end
  always @(prog_clock_out) n_pcl++;

  // counts expected: both-edge select doubles them
  function automatic int exp_count(input int code, input int k);
    return (code == 3) ? 2 * k : k;
  endfunction
  // capture expected: rising-valid captures before the last count
  function automatic logic [15:0] exp_cap(input int code, input int k,
                                          input logic [15:0] old);
    if (code == 0) return 16'(k);
    if (code == 1) return 16'(k - 1);
    return old;
  endfunction
  // bus cycles, request held across one sampling edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1 bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d, be: 2'h3};
    @(posedge ref_clk);
    #1 bus_req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    #1 bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000, be: 2'h3};
    @(posedge ref_clk);
    #1 bus_req = '0;
    d = bus_rdata;
  endtask
  // stop, configure while stopped, then free run
  task automatic start(input logic [7:0] cs, input logic [15:0] cc);
    wr(ADDR_TIMER_MODE_CONTROL, 16'h0000);
    wr(ADDR_COUNT_CLOCK_SELECT, {8'h00, cs});
    wr(ADDR_CAPCOMP_CONTROL, cc);
    wr(ADDR_TIMER_MODE_CONTROL, 16'h0004);
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    wrap_up();
  end

  // main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    bus_req = '0;
    osc_mode_bit = 1'b0;
    void'($urandom(32'hbaec41f1));
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    osc_mode_bit = 1'($urandom % 2);
    rd(ADDR_COUNT_VALUE, got);
    `CHK(got, COUNT_RESET);
    rd(ADDR_COUNT_CLOCK_SELECT, got);
    `CHK(got, {8'h00, CLKSEL_RESET});
    rd(ADDR_TIMER_MODE_CONTROL, got);
    `CHK(got, {8'h00, MODE_RESET});
    rd(8'h7e, got);
    `CHK(got, 16'h0000);
    prev = 16'($urandom % 128);
    wr(ADDR_COUNT_CLOCK_SELECT, prev);
    rd(ADDR_COUNT_CLOCK_SELECT, got);
    `CHK(got, prev);
    $display("test registers done");
    for (int s = 0; s < 2; s++) begin
      n = 1 + $urandom % 12;
      start(s ? 8'h70 : 8'h00, 16'h0004);
      sct_pin_model_i.pulse(s ? 2 : 0, n);
      rd(ADDR_COUNT_VALUE, got);
      `CHK(got, 16'(n));
      rd(ADDR_CAPTURE_COMPARE_SECOND, got);
      `CHK(got, 16'(n));
    end
    $display("test counting done");
    start(8'h00, 16'h0000);
    n = 2 + $urandom % 6;
    wr(ADDR_CAPTURE_COMPARE_FIRST, 16'(n));
    wr(ADDR_CAPTURE_COMPARE_SECOND, 16'(n + 2));
    n_m1 = 0;
    n_m2 = 0;
    sct_pin_model_i.pulse(0, n + 3);
    `CHK(n_m1, 1);
    `CHK(n_m2, 1);
    wr(ADDR_CAPTURE_COMPARE_FIRST, 16'h0001);
    sct_pin_model_i.pulse(0, 3);
    `CHK(n_m1, 1);
    start(8'h00, 16'h0000);
    wr(ADDR_TIMER_MODE_CONTROL, 16'h0002);
    wr(ADDR_CAPTURE_COMPARE_FIRST, 16'h0004);
    wr(ADDR_CAPTURE_COMPARE_SECOND, 16'h00ff);
    wr(ADDR_TIMER_OUTPUT_CONTROL, 16'h0001);
    @(posedge ref_clk);
    #1;
    `CHK(timer_out_pin, 1'b1);
    sct_pin_model_i.pulse(0, 4);
    `CHK(timer_out_pin, 1'b0);
    start(8'h00, 16'h0000);
    wr(ADDR_TIMER_MODE_CONTROL, 16'h000c);
    n = 2 + $urandom % 6;
    wr(ADDR_CAPTURE_COMPARE_FIRST, 16'(n));
    sct_pin_model_i.pulse(0, n + 2);
    rd(ADDR_COUNT_VALUE, got);
    `CHK(got, 16'h0001);
    `CHK(timer_out_pin, 1'b1);
    $display("test compare done");
    prev = 16'h0000;
    foreach (codes[i]) begin
      n = 1 + $urandom % 8;
      start(8'h00, 16'h0001);
      wr(ADDR_EDGE_SELECT_CONTROL, 16'(codes[i] << EDGE_SEL_LSB));
      n_pin = 0;
      sct_pin_model_i.pulse(0, n);
      prev = exp_cap(codes[i], n, prev);
      rd(ADDR_CAPTURE_COMPARE_FIRST, got);
      `CHK(got, prev);
      rd(ADDR_COUNT_VALUE, got);
      `CHK(got, 16'(exp_count(codes[i], n)));
      `CHK(n_pin, exp_count(codes[i], n));
    end
    start(8'h70, 16'h0003);
    wr(ADDR_EDGE_SELECT_CONTROL, 16'h0000);
    n = 1 + $urandom % 8;
    sct_pin_model_i.pulse(2, n);
    sct_pin_model_i.pulse(1, 1);
    rd(ADDR_CAPTURE_COMPARE_FIRST, got);
    `CHK(got, 16'(n));
    $display("test capture done");
    wr(ADDR_TIMER_MODE_CONTROL, 16'h0000);
    sct_pin_model_i.pulse(2, 2);
    rd(ADDR_COUNT_VALUE, got);
    `CHK(got, 16'h0000);
    $display("test stop done");
    wr(ADDR_COUNT_CLOCK_SELECT, 16'h0080);
    repeat (4) @(posedge ref_clk);
    n_pcl = 0;
    sct_pin_model_i.toggle_sub(4);
    `CHK(n_pcl, 4);
    $display("test clock output done");
    wrap_up();
  end
endmodule // testbench
